// ---- design/dbi_pkg.sv ----
/*
  Constants shared by the double-buffered converter host controller.
  Assumes a 25 MHz ref_clk; strobe timings are derived from it.
*/
package dbi_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 40;
  // Least strobe low time in ns, rounded up to whole cycles
  localparam int unsigned STROBE_LOW_NS    = 40;
  localparam int unsigned STROBE_LOW_CYC   =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Gap between first-rank load and second-rank load, in ns
  localparam int unsigned RANK_GAP_NS      = 100;
  localparam int unsigned RANK_GAP_CYC     =
    (RANK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Second-rank pulse high time and select hold after strobe end
  localparam int unsigned UPDATE_HIGH_CYC  = 2;
  localparam int unsigned SEL_HOLD_CYC     = 1;
  localparam int unsigned CNT_W            = 4;
  // ----------------------------------------------------------------
  // Data coding
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W           = 16;
  localparam int unsigned MSB_POS          = 15;
  localparam logic [15:0] OFFSET_ZERO_CODE = 16'h8000;
  // ----------------------------------------------------------------
  // Write modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DBI_MODE_JOINED  = 2'b00,  // all controls tied to one strobe
    DBI_MODE_WRSEL   = 2'b01,  // strobe on first-rank load, select on both
    DBI_MODE_MULTI   = 2'b10   // addressed loads, then shared update
  } dbi_mode_t;
  typedef enum logic [2:0] {
    DBI_ST_IDLE   = 3'b000,
    DBI_ST_SETUP  = 3'b001,
    DBI_ST_STROBE = 3'b010,
    DBI_ST_HOLD   = 3'b011,
    DBI_ST_GAP    = 3'b100,
    DBI_ST_UPDATE = 3'b101
  } dbi_state_t;
endpackage

// ---- design/dbi_host.sv ----
/*
  Host-side write controller for a double-buffered 16-bit converter input.
  Words arrive on a valid/ready stream, pass a two-entry buffer, and are
  written over the converter's select, first-rank load and second-rank
  load pins. Assumes the pins reach the converter directly on this clock.
*/
`timescale 1ns/1ps
// Overview of operation
// - Host inverts bit 15 of twos complement samples before driving.
// - Control pins are always driven; the update line idles high except in multi mode, where it idles low between pulses.
// - Host stretches strobe low time to whole-cycle minimum width.
// - Outside joined mode, host ends write strobe before decoded select rises; in joined mode both rise together.
// - Multi-converter: addressed first-rank loads, then one shared update pulse.
// - Eight-bit hosts assemble bytes externally before loading all 16 bits.
// - Write starts derive synchronously from ref_clk to avoid jitter.
module dbi_host
  import dbi_pkg::*;
#(
  parameter int unsigned NUM_DAC = 3,
  parameter int unsigned SEL_W   = 2
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic [1:0]         mode,
  input  wire logic               twos_comp,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire logic [DATA_W-1:0]  in_data,
  input  wire logic [SEL_W-1:0]   in_dest,
  input  wire logic               in_last,
  output logic [DATA_W-1:0]       dac_data,
  output logic [NUM_DAC-1:0]      decoded_select_n,
  output logic                    first_rank_load_n,
  output logic                    second_rank_load,
  output logic                    busy
);
  // ----------------------------------------------------------------
  // Two-entry input buffer
  // ----------------------------------------------------------------
  // Mode and coding travel with each word, so a stalled word keeps its own
  localparam int unsigned ENT_W = DATA_W + SEL_W + 4;
  logic [ENT_W-1:0] buf_q [2];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       count_q;
  logic             pop;
  logic             push;
  logic [ENT_W-1:0] head;
  logic             head_tc;

  assign in_ready = (count_q != 2'd2);
  assign push     = in_valid && in_ready;
  assign head     = buf_q[rd_ptr_q];
  assign head_tc  = head[DATA_W + SEL_W + 1];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'd0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      buf_q[wr_ptr_q] <= {mode, twos_comp, in_last, in_dest, in_data};
    end
  end

  // ----------------------------------------------------------------
  // Write sequencer
  // ----------------------------------------------------------------
  dbi_state_t        state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [SEL_W-1:0]  dest_q;
  logic              last_q;
  logic              sel_act_q;
  logic              load_act_q;
  logic              upd_q;
  logic [DATA_W-1:0] data_q;
  dbi_mode_t         mode_q;
  logic [DATA_W-1:0] coded;

  // Bit 15 flipped turns twos complement into offset binary
  always_comb begin
    coded = head[DATA_W-1:0];
    if (head_tc) coded = coded ^ OFFSET_ZERO_CODE;
  end

  // Starts are taken on ref_clk only, so strobes carry no jitter
  assign pop = (state_q == DBI_ST_IDLE) && (count_q != 2'd0);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q    <= DBI_ST_IDLE;
      cnt_q      <= '0;
      dest_q     <= '0;
      last_q     <= 1'b0;
      sel_act_q  <= 1'b0;
      load_act_q <= 1'b0;
      upd_q      <= 1'b0;
      data_q     <= '0;
      mode_q     <= DBI_MODE_JOINED;
    end else begin
      case (state_q)
        DBI_ST_IDLE: begin
          if (pop) begin
            data_q  <= coded;
            dest_q  <= head[DATA_W +: SEL_W];
            last_q  <= head[DATA_W + SEL_W];
            mode_q  <= dbi_mode_t'(head[ENT_W-1 -: 2]);
            state_q <= DBI_ST_SETUP;
          end
        end
        DBI_ST_SETUP: begin
          // Data stands one cycle before the strobe falls
          sel_act_q  <= 1'b1;
          load_act_q <= (mode_q != DBI_MODE_JOINED);
          upd_q      <= 1'b0;
          cnt_q      <= CNT_W'(STROBE_LOW_CYC);
          state_q    <= DBI_ST_STROBE;
        end
        DBI_ST_STROBE: begin
          if (cnt_q > CNT_W'(1)) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            // Strobe ends first; select holds on to keep data hold, except in joined mode where select ends with it
            load_act_q <= 1'b0;
            if (mode_q == DBI_MODE_JOINED) sel_act_q <= 1'b0;
            cnt_q   <= CNT_W'(SEL_HOLD_CYC);
            state_q <= DBI_ST_HOLD;
          end
        end
        DBI_ST_HOLD: begin
          sel_act_q <= 1'b0;
          if (mode_q == DBI_MODE_MULTI && last_q) begin
            cnt_q   <= CNT_W'(RANK_GAP_CYC);
            state_q <= DBI_ST_GAP;
          end else begin
            state_q <= DBI_ST_IDLE;
          end
        end
        DBI_ST_GAP: begin
          if (cnt_q > CNT_W'(1)) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            upd_q   <= 1'b1;
            cnt_q   <= CNT_W'(UPDATE_HIGH_CYC);
            state_q <= DBI_ST_UPDATE;
          end
        end
        DBI_ST_UPDATE: begin
          if (cnt_q > CNT_W'(1)) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            upd_q   <= 1'b0;
            state_q <= DBI_ST_IDLE;
          end
        end
        default: state_q <= DBI_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Select pins never float; unselected ones stay high
  genvar g;
  generate
    for (g = 0; g < NUM_DAC; g++) begin : g_sel
      assign decoded_select_n[g] = ~(sel_act_q && (dest_q == SEL_W'(g)));
    end
  endgenerate

  always_comb begin
    case (mode_q)
      DBI_MODE_JOINED: begin
        first_rank_load_n = ~sel_act_q;
        second_rank_load  = ~sel_act_q;
      end
      DBI_MODE_WRSEL: begin
        first_rank_load_n = ~load_act_q;
        second_rank_load  = ~sel_act_q;
      end
      default: begin
        first_rank_load_n = ~load_act_q;
        second_rank_load  = upd_q;
      end
    endcase
  end

  assign dac_data = data_q;
  assign busy     = (state_q != DBI_ST_IDLE) || (count_q != 2'd0);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] low_len_q;

  // Length of the current first-rank load pulse, saturating
  always_ff @(posedge ref_clk) begin
    if (!rst_n || first_rank_load_n) begin
      low_len_q <= '0;
    end else if (low_len_q != '1) begin
      low_len_q <= low_len_q + CNT_W'(1);
    end
  end

  AST_STROBE_BEFORE_SEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q == DBI_MODE_WRSEL && $rose(sel_act_q == 1'b0)) |-> $past(!load_act_q))
    else $error("select rose before write strobe ended");
  AST_STROBE_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(first_rank_load_n) |-> (low_len_q >= CNT_W'(STROBE_LOW_CYC)))
    else $error("strobe low time too short");
  AST_UPD_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(upd_q) |-> upd_q ##1 upd_q ##1 !upd_q)
    else $error("update pulse width wrong");
  AST_UPD_ONLY_MULTI: assert property (@(posedge ref_clk) disable iff (!rst_n)
    upd_q |-> (mode_q == DBI_MODE_MULTI) && !sel_act_q)
    else $error("update pulse outside shared update");
  AST_DATA_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q != DBI_ST_IDLE) |=> $stable(data_q))
    else $error("data changed during write");
  AST_MSB_INVERT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pop && head_tc) |=> (data_q[MSB_POS] != $past(head[MSB_POS])))
    else $error("msb not inverted");
  AST_JOINED_TIE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q == DBI_MODE_JOINED) |-> (first_rank_load_n == second_rank_load))
    else $error("joined strobes diverge");
  AST_GAP_BEFORE_UPD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(upd_q) |-> $past(state_q, 1) == DBI_ST_GAP)
    else $error("update without gap");
endmodule // dbi_host

// ---- verification/dbi_conv_model.sv ----
/*
  Behavioural model of one double-buffered converter input stage.
  Assumes the host pins arrive directly; each rank is a level latch.
*/
`timescale 1ns/1ps
module dbi_conv_model
  import dbi_pkg::*;
(
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              select_n,
  input  wire logic              first_rank_load_n,
  input  wire logic              second_rank_load,
  output logic [DATA_W-1:0]      conv_code
);
  // ----------------------------------------------------------------
  // Two ranks
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] first_q;
  // Bits taken as given, high counts its weight
  always_latch begin
    if (!select_n && !first_rank_load_n) begin
      first_q <= data_in;
    end
  end
  // Update line is not gated by select, so one pulse serves all
  always_latch begin
    if (second_rank_load) begin
      conv_code <= first_q;
    end
  end
endmodule // dbi_conv_model

// ---- verification/dac_double_buffer_input_tb.sv ----
/*
  Self-checking bench for dbi_host with three converter models.
  Assumes 25 MHz ref_clk; results are compared whenever busy falls.
*/
`timescale 1ns/1ps
module dac_double_buffer_input_tb
  import dbi_pkg::*;
;
  localparam int unsigned NUM_DAC = 3;
  localparam int unsigned SEL_W   = 2;
  localparam int unsigned MAX_CYC = 20000;
  typedef struct {logic [SEL_W-1:0] dest; logic [DATA_W-1:0] code;} dbi_note_t;
  logic               ref_clk, rst_n, twos_comp, in_valid, in_ready, in_last;
  logic               first_rank_load_n, second_rank_load, busy, busy_q, ld_q;
  logic [1:0]         mode, batch_mode;
  logic [DATA_W-1:0]  in_data, dac_data, d;
  logic [SEL_W-1:0]   in_dest;
  logic [NUM_DAC-1:0] decoded_select_n, sel_q;
  logic [DATA_W-1:0]  conv_code [NUM_DAC];
  logic [DATA_W-1:0]  edge_codes [3] = '{16'h0000, 16'h8000, 16'hffff};
  dbi_note_t          notes [$];
  int                 num_errors, checks, cycles, stalls, low_cyc;
  logic [31:0]        rng;
  // ----------------------------------------------------------------
  // Design and converters
  // ----------------------------------------------------------------
  dbi_host #(.NUM_DAC(NUM_DAC), .SEL_W(SEL_W)) dbi_host_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .mode(mode), .twos_comp(twos_comp),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_dest(in_dest),
    .in_last(in_last), .dac_data(dac_data), .decoded_select_n(decoded_select_n),
    .first_rank_load_n(first_rank_load_n), .second_rank_load(second_rank_load),
    .busy(busy));
  for (genvar g = 0; g < NUM_DAC; g++) begin : g_conv
    dbi_conv_model dbi_conv_model_inst (
      .data_in(dac_data), .select_n(decoded_select_n[g]),
      .first_rank_load_n(first_rank_load_n), .second_rank_load(second_rank_load),
      .conv_code(conv_code[g]));
  end
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Holds the word until accepted; ready is steady at the falling edge
  task automatic push(input logic [1:0] m, input logic tc, input logic [DATA_W-1:0] w,
                      input logic [SEL_W-1:0] dst, input logic lst);
    logic      rdy;
    dbi_note_t nt;
    int        n;
    mode = m;
    twos_comp = tc;
    in_data = w;
    in_dest = dst;
    in_last = lst;
    in_valid = 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      rdy = in_ready;
      @(posedge ref_clk);
      n++;
      if (rdy !== 1'b1) stalls++;
    end while (rdy !== 1'b1 && n < 100);
    check(rdy === 1'b1, "word never accepted");
    nt.dest = dst;
    nt.code = tc ? {~w[MSB_POS], w[MSB_POS-1:0]} : w;
    notes.push_back(nt);
    #1;
  endtask
  task automatic drain();
    int n;
    in_valid = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    check(n < 200, "busy stuck high");
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (rst_n === 1'b1 && batch_mode != 2'b00 && (decoded_select_n & ~sel_q) != '0)
      check(ld_q === 1'b1, "select rose before strobe ended");
    if (rst_n === 1'b1 && busy_q === 1'b1 && busy === 1'b0) begin
      foreach (notes[i]) begin
        logic later;
        later = 1'b0;
        for (int j = i + 1; j < notes.size(); j++) if (notes[j].dest == notes[i].dest) later = 1'b1;
        if (!later) check(conv_code[notes[i].dest] === notes[i].code, "converter code");
      end
      notes.delete();
    end
    if (rst_n === 1'b1 && first_rank_load_n === 1'b1 && ld_q === 1'b0)
      check(low_cyc >= STROBE_LOW_CYC, "strobe low too short");
    low_cyc <= (first_rank_load_n === 1'b0) ? low_cyc + 1 : 0;
    busy_q <= busy;
    sel_q  <= decoded_select_n;
    ld_q   <= first_rank_load_n;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= MAX_CYC) begin
      num_errors++;
      $display("BAD %0t run too long", $time);
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    mode = 2'h0;
    twos_comp = 1'b0;
    in_valid = 1'b0;
    in_data = 16'h0000;
    in_dest = '0;
    in_last = 1'b0;
    batch_mode = 2'h0;
    rng = 32'h846a;
    num_errors = 0;
    checks = 0;
    stalls = 0;
    cycles = 0;
    low_cyc = 0;
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    check(decoded_select_n === '1 && first_rank_load_n === 1'b1, "idle controls");
    check(second_rank_load === 1'b1 && dac_data === 16'h0000, "idle update or data");
    // Back to back words per mode so the buffer fills and refuses
    for (int m = 0; m < 2; m++) begin
      batch_mode = 2'(m);
      for (int k = 0; k < 6; k++) begin
        rng = xs(rng);
        push(2'(m), rng[16], rng[15:0], SEL_W'(rng[23:20] % NUM_DAC), 1'b1);
      end
      drain();
    end
    // Groups of addressed loads ending in one shared update
    batch_mode = 2'h2;
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 3; k++) begin
        rng = xs(rng);
        d = (g == 0) ? edge_codes[k] : rng[15:0];
        push(2'h2, g[0], d, SEL_W'(k), k == 2);
      end
      // Each group is checked before the next one overwrites it
      drain();
    end
    check(stalls > 0, "buffer never refused a word");
    wrap_up();
  end
endmodule // dac_double_buffer_input_tb
